// *** common/dmasac_defines.vh ***
`ifndef DMASAC_DEFINES_VH
`define DMASAC_DEFINES_VH
`define DMASAC_AW 18
`define DMASAC_IDX_IRQ_STATUS 16'hff30
`define DMASAC_IDX_IRQ_CLEAR 16'hff31
`define DMASAC_IDX_IRQ_ENABLE 16'hff32
`define DMASAC_IDX_CHA_CTRL 16'hff37
`define DMASAC_IDX_MEM_ADDR 16'hff38
`define DMASAC_IDX_COUNT_HI 16'hff3c
`define DMASAC_IDX_COUNT_LO 16'hff3d
`define DMASAC_IDX_IO_ADDR 16'hff3e
`define DMASAC_IDX_CTRL 16'hff3f
`define DMASAC_CTRL_RESET 8'h00
`define DMASAC_ENABLE_BIT 7
`define DMASAC_SIZE_BIT 6
`define DMASAC_DIR_BIT 5
`define DMASAC_REPEAT_BIT 4
`define DMASAC_IRQEN_BIT 3
`define DMASAC_SEL_MSB 2
`define DMASAC_RX_FULL_SEL 3'h5
`define DMASAC_TOP_BYTE 8'hff
`define DMASAC_IO_PREFIX 16'hffff
`define DMASAC_STEP_BYTE 24'h000001
`define DMASAC_STEP_WORD 24'h000002
`define DMASAC_IRQ_END 0
`define DMASAC_IRQ_DONE 1
`endif

// *** rtl/dmasac_channel.v ***
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "dmasac_defines.vh"
module dmasac_channel (
    pclk,
    presetn,
    ce,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    activation_req,
    xfer_valid,
    xfer_src_addr,
    xfer_dst_addr,
    xfer_word,
    xfer_done,
    full_address_mode,
    transfer_end_irq,
    irq
);
    // ==========================================================
    // Parameters
    // Three select bits can address at most eight sources.
    parameter N_SOURCES = 8;

    input wire pclk;
    input wire presetn;
    input wire ce;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [`DMASAC_AW-1:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire [N_SOURCES-1:0] activation_req;
    output reg xfer_valid;
    output reg [23:0] xfer_src_addr;
    output reg [23:0] xfer_dst_addr;
    output reg xfer_word;
    input wire xfer_done;
    output wire full_address_mode;
    output wire transfer_end_irq;
    output wire irq;

    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    // ==========================================================
    // Register state
    reg [1:0] state;
    reg [7:0] control;
    reg [2:0] cha_select;
    reg [23:0] mem_addr;
    reg [7:0] io_side_address;
    reg [7:0] count_upper_byte;
    reg [7:0] count_lower_byte;
    reg [1:0] irq_status;
    reg [1:0] irq_enable;

    reg [1:0] next_state;
    reg [7:0] next_control;
    reg [23:0] next_mem_addr;
    reg [15:0] next_count;
    reg [1:0] irq_event;
    reg [31:0] next_prdata;

    function is_index;
        input [`DMASAC_AW-1:0] addr;
        input [15:0] idx;
        begin
            is_index = (addr[`DMASAC_AW-1:2] == idx) && (addr[1:0] == 2'b00);
        end
    endfunction

    // ==========================================================
    // Decode
    wire hit_status = is_index(paddr, `DMASAC_IDX_IRQ_STATUS);
    wire hit_clear = is_index(paddr, `DMASAC_IDX_IRQ_CLEAR);
    wire hit_enable = is_index(paddr, `DMASAC_IDX_IRQ_ENABLE);
    wire hit_cha = is_index(paddr, `DMASAC_IDX_CHA_CTRL);
    wire hit_mem = is_index(paddr, `DMASAC_IDX_MEM_ADDR);
    wire hit_chi = is_index(paddr, `DMASAC_IDX_COUNT_HI);
    wire hit_clo = is_index(paddr, `DMASAC_IDX_COUNT_LO);
    wire hit_io = is_index(paddr, `DMASAC_IDX_IO_ADDR);
    wire hit_ctrl = is_index(paddr, `DMASAC_IDX_CTRL);
    wire hit_any = hit_status | hit_clear | hit_enable | hit_cha | hit_mem |
        hit_chi | hit_clo | hit_io | hit_ctrl;
    wire wr = psel & penable & pwrite & ce & hit_any;

    // Every access completes in its first access cycle.
    assign pready = penable;
    assign pslverr = psel & penable & ~hit_any;

    // ==========================================================
    // Mode and source decode
    assign full_address_mode = cha_select[2] & cha_select[1];
    wire en = control[`DMASAC_ENABLE_BIT];
    wire repeat_select_bit = control[`DMASAC_REPEAT_BIT];
    wire end_interrupt_enable = control[`DMASAC_IRQEN_BIT];
    wire repeat_mode = repeat_select_bit & ~end_interrupt_enable;
    wire idle_mode = repeat_select_bit & end_interrupt_enable;
    wire [2:0] src_sel = control[`DMASAC_SEL_MSB:0];
    wire rx_full = (src_sel == `DMASAC_RX_FULL_SEL);
    wire req = activation_req[src_sel];
    wire start = (state == ST_IDLE) & en & req & ~full_address_mode;
    wire finish = (state == ST_BUSY) & xfer_done;
    wire [15:0] count = {count_upper_byte, count_lower_byte};
    wire [23:0] io_addr = {`DMASAC_IO_PREFIX, io_side_address};
    wire [23:0] step = control[`DMASAC_SIZE_BIT] ? `DMASAC_STEP_WORD :
        `DMASAC_STEP_BYTE;

    // ==========================================================
    // Next-state logic for the transfer sequence
    always @* begin
        next_state = state;
        next_control = control;
        next_mem_addr = mem_addr;
        next_count = count;
        irq_event = 2'b00;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (finish) begin
                    next_state = ST_IDLE;
                    irq_event[`DMASAC_IRQ_DONE] = 1'b1;
                    if (!idle_mode) begin
                        if (control[`DMASAC_DIR_BIT]) begin
                            next_mem_addr = mem_addr - step;
                        end else begin
                            next_mem_addr = mem_addr + step;
                        end
                    end
                    if (repeat_mode) begin
                        if (count_upper_byte == 8'h01) begin
                            next_count = {count_lower_byte,
                                count_lower_byte};
                        end else begin
                            next_count = {count_upper_byte - 8'h01,
                                count_lower_byte};
                        end
                    end else begin
                        next_count = count - 16'h0001;
                        if (count == 16'h0001) begin
                            next_control[`DMASAC_ENABLE_BIT] = 1'b0;
                            if (end_interrupt_enable) begin
                                irq_event[`DMASAC_IRQ_END] = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Transfer sequencer state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Software registers with a reset value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= `DMASAC_CTRL_RESET;
            cha_select <= 3'h0;
            irq_enable <= 2'h0;
        end else if (ce) begin
            // Software writes win over the hardware enable clear.
            if (wr && hit_ctrl) begin
                control <= pwdata[7:0];
            end else begin
                control <= next_control;
            end
            if (wr && hit_cha) begin
                cha_select <= pwdata[2:0];
            end
            if (wr && hit_enable) begin
                irq_enable <= pwdata[1:0];
            end
        end
    end

    // ==========================================================
    // Sticky event flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
        end else if (ce) begin
            // An event in the clearing cycle wins, so none is lost.
            if (wr && hit_clear) begin
                irq_status <= (irq_status & ~pwdata[1:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    // ==========================================================
    // Transfer request towards the far side
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_valid <= 1'b0;
            xfer_src_addr <= 24'h000000;
            xfer_dst_addr <= 24'h000000;
            xfer_word <= 1'b0;
        end else if (ce) begin
            if (start) begin
                xfer_valid <= 1'b1;
                xfer_word <= control[`DMASAC_SIZE_BIT];
                if (rx_full) begin
                    xfer_src_addr <= io_addr;
                    xfer_dst_addr <= mem_addr;
                end else begin
                    xfer_src_addr <= mem_addr;
                    xfer_dst_addr <= io_addr;
                end
            end else if (finish) begin
                xfer_valid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read multiplexer
    always @* begin
        next_prdata = 32'h00000000;
        if (hit_status) begin
            next_prdata[1:0] = irq_status;
        end
        if (hit_enable) begin
            next_prdata[1:0] = irq_enable;
        end
        if (hit_cha) begin
            next_prdata[2:0] = cha_select;
        end
        if (hit_mem) begin
            next_prdata = {`DMASAC_TOP_BYTE, mem_addr};
        end
        if (hit_chi) begin
            next_prdata[7:0] = count_upper_byte;
        end
        if (hit_clo) begin
            next_prdata[7:0] = count_lower_byte;
        end
        if (hit_io) begin
            next_prdata[7:0] = io_side_address;
        end
        if (hit_ctrl) begin
            next_prdata[7:0] = control;
        end
    end

    // ==========================================================
    // Read data, captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    // ==========================================================
    // Memory-side address
    // No reset here on purpose: the content survives reset.
    always @(posedge pclk) begin
        if (ce) begin
            if (wr && hit_mem) begin
                mem_addr <= pwdata[23:0];
            end else begin
                mem_addr <= next_mem_addr;
            end
        end
    end

    // ==========================================================
    // I/O-side address
    // Only software moves it; a transfer never does.
    always @(posedge pclk) begin
        if (ce && wr && hit_io) begin
            io_side_address <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Transfer count
    // Software must load both bytes before it enables the channel.
    always @(posedge pclk) begin
        if (ce) begin
            if (wr && hit_chi) begin
                count_upper_byte <= pwdata[7:0];
            end else begin
                count_upper_byte <= next_count[15:8];
            end
            if (wr && hit_clo) begin
                count_lower_byte <= pwdata[7:0];
            end else begin
                count_lower_byte <= next_count[7:0];
            end
        end
    end

    // ==========================================================
    // Interrupt outputs
    assign transfer_end_irq = irq_status[`DMASAC_IRQ_END];
    assign irq = |(irq_status & irq_enable);

endmodule // dmasac_channel

// *** bench/dmasac_far_end.sv ***
`timescale 1ns/100ps
// ==========
// Memory and peripheral side: ends each pending transfer with a one-cycle
// done pulse, either at once or after a few wait cycles.
module dmasac_far_end (
    input wire pclk,
    input wire presetn,
    input wire xfer_valid,
    input wire slow,
    output reg xfer_done
);
    reg [2:0] wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_done <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (xfer_done) begin
            xfer_done <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (xfer_valid) begin
            if (wait_cnt >= (slow ? 3'h3 : 3'h0))
                xfer_done <= 1'b1;
            else
                wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule // dmasac_far_end

// *** bench/dmasac_channel_asserts.sv ***
`timescale 1ns/100ps
`include "dmasac_defines.vh"
// ==========
// Port-level checks of the channel.
module dmasac_channel_asserts (
    input wire pclk, presetn, ce, psel, penable, pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire pready, pslverr,
    input wire [7:0] activation_req,
    input wire xfer_valid, xfer_word, xfer_done,
    input wire [23:0] xfer_src_addr, xfer_dst_addr,
    input wire full_address_mode, transfer_end_irq, irq
);
    wire wr_cha = psel && penable && pwrite && ce &&
        paddr == {`DMASAC_IDX_CHA_CTRL, 2'b00};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_valid_holds: assert property (xfer_valid && !xfer_done |=> xfer_valid)
        else $error("transfer dropped before done");
    a_done_ends: assert property (xfer_valid && xfer_done |=> !xfer_valid)
        else $error("transfer still pending after done");
    a_io_prefix: assert property (xfer_valid |->
        xfer_src_addr[23:8] == 16'hffff || xfer_dst_addr[23:8] == 16'hffff)
        else $error("no side carries the io prefix");
    a_full_set: assert property (wr_cha && pwdata[2:1] == 2'b11
        |=> full_address_mode) else $error("full mode not entered");
    a_full_clear: assert property (wr_cha && pwdata[2:1] != 2'b11
        |=> !full_address_mode) else $error("full mode not left");
    a_no_full_start: assert property ($rose(xfer_valid)
        |-> !$past(full_address_mode)) else $error("start in full mode");
    a_start_req: assert property ($rose(xfer_valid)
        |-> $past(activation_req) != 8'h00) else $error("start without req");
    a_top_byte: assert property (psel && !penable && !pwrite && ce &&
        paddr == {`DMASAC_IDX_MEM_ADDR, 2'b00} |=> prdata[31:24] == 8'hff)
        else $error("address top byte not ones");
    a_end_cause: assert property ($rose(transfer_end_irq)
        |-> $past(xfer_done) && $past(xfer_valid))
        else $error("end interrupt without a transfer");
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule // dmasac_channel_asserts
bind dmasac_channel dmasac_channel_asserts u_chk (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .activation_req(activation_req),
    .xfer_valid(xfer_valid), .xfer_word(xfer_word), .xfer_done(xfer_done),
    .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
    .full_address_mode(full_address_mode),
    .transfer_end_irq(transfer_end_irq), .irq(irq));

// *** bench/tb.sv ***
`timescale 1ns/100ps
`include "dmasac_defines.vh"
// ==========
// Bench with an integer model of the channel.
module tb;
    reg pclk, presetn, ce, psel, penable, pwrite, slow, err;
    reg [17:0] paddr;
    reg [31:0] pwdata, rd;
    reg [7:0] activation_req;
    wire [31:0] prdata;
    wire pready, pslverr, xfer_valid, xfer_word, xfer_done;
    wire full_address_mode, transfer_end_irq, irq;
    wire [23:0] xfer_src_addr, xfer_dst_addr;
    integer seed, failures, n_tests, mem, io, hi, lo, ctrl, c;
    dmasac_channel uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .activation_req(activation_req), .xfer_valid(xfer_valid),
        .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
        .xfer_word(xfer_word), .xfer_done(xfer_done),
        .full_address_mode(full_address_mode),
        .transfer_end_irq(transfer_end_irq), .irq(irq));
    dmasac_far_end far (.pclk(pclk), .presetn(presetn),
        .xfer_valid(xfer_valid), .slow(slow), .xfer_done(xfer_done));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [15:0] idx, input [31:0] wd);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {idx, 2'b00};
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Model of one transfer; the request is dropped as soon as it is taken
    // so that a level request cannot start a second transfer behind it.
    task xfer;
        begin
            activation_req <= ($random(seed) & ~(1 << (ctrl & 7))) |
                (1 << (ctrl & 7));
            while (xfer_valid !== 1'b1) begin
                @(posedge pclk);
            end
            activation_req <= 8'h00;
            chk(xfer_word, (ctrl >> 6) & 1);
            c = (ctrl & 7) == 5;
            chk(xfer_src_addr, c ? 24'hffff00 | io : mem & 24'hffffff);
            chk(xfer_dst_addr, c ? mem & 24'hffffff : 24'hffff00 | io);
            while (xfer_valid !== 1'b0) begin
                @(posedge pclk);
            end
            c = (ctrl & 8'h40) ? 2 : 1;
            if ((ctrl & 8'h18) != 8'h18)
                mem = (ctrl & 8'h20) ? mem - c : mem + c;
            if ((ctrl & 8'h18) == 8'h10) begin
                hi = hi - 1;
                if (hi == 0)
                    hi = lo;
            end else begin
                c = hi * 256 + lo - 1;
                hi = c >> 8;
                lo = c & 255;
                if (c == 0)
                    ctrl = ctrl & 8'h7f;
            end
        end
    endtask
    task run(input [7:0] c0, input [7:0] h0, input [7:0] l0, input integer nx);
        begin
            mem = $random(seed);
            io = $random(seed) & 255;
            ctrl = c0;
            hi = h0;
            lo = l0;
            slow <= $random(seed) & 1;
            apb(1, `DMASAC_IDX_MEM_ADDR, mem);
            apb(1, `DMASAC_IDX_IO_ADDR, io);
            apb(1, `DMASAC_IDX_COUNT_HI, hi);
            apb(1, `DMASAC_IDX_COUNT_LO, lo);
            apb(1, `DMASAC_IDX_CTRL, ctrl);
            repeat (nx) xfer;
            apb(0, `DMASAC_IDX_MEM_ADDR, 0);
            chk(rd, (mem & 32'hffffff) | 32'hff000000);
            apb(0, `DMASAC_IDX_IO_ADDR, 0);
            chk(rd, io);
            apb(0, `DMASAC_IDX_COUNT_HI, 0);
            chk(rd, hi);
            apb(0, `DMASAC_IDX_COUNT_LO, 0);
            chk(rd, lo);
            apb(0, `DMASAC_IDX_CTRL, 0);
            chk(rd, ctrl);
            $display("test with control %h done", c0);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d, mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #400000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        seed = 32'hfa18;
        failures = 0;
        n_tests = 0;
        {presetn, psel, penable, pwrite, slow, paddr, pwdata} = 0;
        ce = 1'b1;
        activation_req = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `DMASAC_IDX_CTRL, 0);
        chk(rd, 8'h00);
        apb(0, 16'hff00, 0);
        chk(err, 1'b1);
        apb(1, `DMASAC_IDX_IRQ_ENABLE, 1);
        run(8'h88, 8'h00, 8'h03, 3);
        chk(irq, 1'b1);
        apb(0, `DMASAC_IDX_IRQ_STATUS, 0);
        chk(rd, 3);
        apb(1, `DMASAC_IDX_IRQ_ENABLE, 0);
        chk(irq, 1'b0);
        apb(1, `DMASAC_IDX_IRQ_ENABLE, 1);
        apb(1, `DMASAC_IDX_IRQ_CLEAR, 3);
        chk(irq, 1'b0);
        run(8'he5, 8'h00, 8'h02, 2);
        run(8'h93, 8'h02, 8'h03, 4);
        run(8'h9c, 8'h00, 8'h02, 2);
        chk(transfer_end_irq, 1'b1);
        apb(1, `DMASAC_IDX_CHA_CTRL, 6);
        chk(full_address_mode, 1'b1);
        apb(1, `DMASAC_IDX_CTRL, 8'h80);
        activation_req <= 8'h01;
        repeat (4) @(posedge pclk);
        chk(xfer_valid, 1'b0);
        activation_req <= 8'h00;
        apb(1, `DMASAC_IDX_CHA_CTRL, 2);
        chk(full_address_mode, 1'b0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `DMASAC_IDX_MEM_ADDR, 0);
        chk(rd, (mem & 32'hffffff) | 32'hff000000);
        apb(0, `DMASAC_IDX_IO_ADDR, 0);
        chk(rd, io);
        apb(0, `DMASAC_IDX_COUNT_HI, 0);
        chk(rd, hi);
        apb(0, `DMASAC_IDX_COUNT_LO, 0);
        chk(rd, lo);
        apb(0, `DMASAC_IDX_CTRL, 0);
        chk(rd, `DMASAC_CTRL_RESET);
        $display("reset retention test done");
        report_and_stop;
    end
endmodule // tb
